// ### bench/amp_fault_indicator_pin_checker.sv
// Port-level concurrent checks for the amplifier diagnostic block.
// Assumes the block's ports only; bound to every instance of it.
`timescale 1ns/100ps
module amp_fault_indicator_pin_checker
	import amp_fault_indicator_pin_pkg::*;
(
	// Inputs seen
	input wire logic clock,
	input wire logic reset,
	input wire logic control_write,
	input wire logic [7:0] control_byte_one,
	input wire logic [7:0] control_byte_two,
	input wire logic status_read,
	input wire logic i2c_mode,
	input wire logic temp_prewarn,
	input wire logic temp_max,
	input wire logic [1:0] current_mismatch,
	input wire logic [1:0] short_fault,
	// Outputs seen
	input wire logic [7:0] channel_one_status_byte,
	input wire logic [7:0] channel_two_status_byte,
	input wire logic [7:0] shared_status_byte,
	input wire logic clip_level_high,
	input wire logic prewarn_level_low,
	input wire logic gain_reduce,
	input wire logic [1:0] channel_off,
	input wire logic fault_indicator_pin_out,
	input wire logic fault_indicator_pin_oe,
	input wire logic overdrive_pin_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	AST_PINS_LOW: assert property (!fault_indicator_pin_out && !overdrive_pin_out)
		else $error("indicator pin driven high");
	AST_RESET_VAL: assert property ($fell(reset) |-> shared_status_byte == SHARED_RESET
		&& channel_one_status_byte == CH_RESET && !clip_level_high && !prewarn_level_low)
		else $error("values after reset wrong");
	AST_LEVEL_DEFAULT: assert property (!i2c_mode [*5] |-> !clip_level_high && !prewarn_level_low)
		else $error("level not at default without serial control");
	AST_CLIP_SEL: assert property (i2c_mode [*4] ##0 control_write
		|-> ##2 clip_level_high == $past(control_byte_two[C2_CLIP_LEVEL], 2))
		else $error("clip level does not follow control");
	AST_GAIN_FOLLOW: assert property (temp_prewarn [*5] |-> gain_reduce)
		else $error("gain not reduced on pre-warning");
	AST_MAXTEMP_OFF: assert property (temp_max [*5] |-> channel_off == 2'b11 && fault_indicator_pin_oe)
		else $error("max temperature not acted on");
	AST_MISMATCH_OFF: assert property (current_mismatch[1] [*5] |-> channel_off[1])
		else $error("mismatched channel left on");
	AST_SHORT_LATCH: assert property (short_fault[0] [*5] |-> channel_one_status_byte[S_SHORT])
		else $error("short not latched");
	AST_OFFSET_ON_READ: assert property (i2c_mode [*4] ##0 status_read
		|=> channel_one_status_byte[S_OFFSET] && channel_two_status_byte[S_OFFSET])
		else $error("offset bits not set by read");
	AST_AC_CLEAR: assert property (control_write && !control_byte_one[C1_AC_EN]
		|-> ##[1:3] !(channel_one_status_byte[S_AC] || channel_two_status_byte[S_AC]))
		else $error("load flag kept with detection off");
	cover property (channel_one_status_byte[S_AC] && channel_two_status_byte[S_AC]);
	cover property (i2c_mode && status_read);
	cover property (i2c_mode && fault_indicator_pin_oe);
endmodule
bind amp_load_fault_indicator_pin_reporting amp_fault_indicator_pin_checker amp_fault_indicator_pin_checker_inst (.*);

// ### bench/host_model.sv
// Host stand-in: issues control writes and status read strobes.
// Assumes the block clock; changes its outputs on the falling edge.
`timescale 1ns/100ps
module host_model (
	// Clock
	input wire logic clock,
	// Control and read strobes
	output logic control_write,
	output logic [7:0] control_byte_one,
	output logic [7:0] control_byte_two,
	output logic [7:0] control_byte_three,
	output logic status_read
);
	initial begin
		control_write = 1'b0;
		status_read = 1'b0;
		{control_byte_one, control_byte_two, control_byte_three} = 24'h000000;
	end
	// Bytes stay put after the strobe, as the block expects
	task automatic write_ctrl(input logic [23:0] b);
		@(negedge clock);
		{control_byte_one, control_byte_two, control_byte_three} = b;
		control_write = 1'b1;
		@(negedge clock);
		control_write = 1'b0;
	endtask
	// Callers read twice when present rather than past status is wanted
	task automatic read_status();
		@(negedge clock);
		status_read = 1'b1;
		@(negedge clock);
		status_read = 1'b0;
	endtask
endmodule

// ### bench/test_amp_load_fault_indicator_pin_reporting.sv
// Self-checking bench for the amplifier diagnostic block.
// Host stand-in drives control and reads; the bench drives analog levels.
`timescale 1ns/100ps
module test_amp_load_fault_indicator_pin_reporting;
	import amp_fault_indicator_pin_pkg::*;
	logic clock, reset, i2c_mode, startup_active, startup_complete, svr_above_low, svr_above_half, dc_settling_near;
	logic supply_low, dc_measure_done, temp_prewarn, temp_max, control_write, status_read;
	logic [1:0] current_upper, load_open, load_line, current_mismatch, short_fault, offset_high, clip_detect;
	logic [7:0] control_byte_one, control_byte_two, control_byte_three, ch1, ch2, shared;
	logic dc_offset_ramp, clip_level_high, prewarn_level_low, gain_reduce, fault_out, fault_oe, od_out, od_oe;
	logic [1:0] channel_off;
	logic [47:0] notes[$];
	logic [47:0] note;
	int errors, n_compared;
	host_model host_model_inst (.clock(clock), .control_write(control_write), .control_byte_one(control_byte_one),
		.control_byte_two(control_byte_two), .control_byte_three(control_byte_three), .status_read(status_read));
	amp_load_fault_indicator_pin_reporting amp_load_fault_indicator_pin_reporting_inst (.clock(clock), .reset(reset),
		.control_write(control_write), .control_byte_one(control_byte_one), .control_byte_two(control_byte_two),
		.control_byte_three(control_byte_three), .status_read(status_read), .i2c_mode(i2c_mode),
		.startup_active(startup_active), .startup_complete(startup_complete), .svr_above_low(svr_above_low),
		.svr_above_half(svr_above_half), .dc_settling_near(dc_settling_near), .supply_low(supply_low),
		.dc_measure_done(dc_measure_done), .temp_prewarn(temp_prewarn), .temp_max(temp_max),
		.current_upper(current_upper), .load_open(load_open), .load_line(load_line),
		.current_mismatch(current_mismatch), .short_fault(short_fault), .offset_high(offset_high),
		.clip_detect(clip_detect), .channel_one_status_byte(ch1), .channel_two_status_byte(ch2),
		.shared_status_byte(shared), .dc_offset_ramp(dc_offset_ramp), .clip_level_high(clip_level_high),
		.prewarn_level_low(prewarn_level_low), .gain_reduce(gain_reduce), .channel_off(channel_off),
		.fault_indicator_pin_in(~fault_oe), .fault_indicator_pin_out(fault_out), .fault_indicator_pin_oe(fault_oe),
		.overdrive_pin_in(~od_oe), .overdrive_pin_out(od_out), .overdrive_pin_oe(od_oe));
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Async inputs need two sync stages plus a register
	task automatic settle();
		repeat (5) @(negedge clock);
	endtask
	task automatic rd(input logic [23:0] mask, input logic [23:0] exp);
		notes.push_back({mask, exp});
		host_model_inst.read_status();
		settle();
	endtask
	// Peak-current comparator toggling at the 800 ns link rate
	task automatic crossings(input int n);
		repeat (n) begin
			current_upper = 2'b11;
			#400;
			current_upper = 2'b00;
			#400;
		end
	endtask
	// Bytes are taken as they stand in the read cycle, before the clear lands
	always @(posedge clock) begin
		if (status_read === 1'b1) begin
			note = notes.pop_front();
			check("status bytes", {ch1, ch2, shared} & note[47:24], note[23:0]);
		end
	end
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	initial begin
		#3000000;
		errors++;
		complete_run();
	end
	initial begin
		reset = 1'b1;
		{i2c_mode, startup_active, startup_complete, svr_above_low, svr_above_half, dc_settling_near, supply_low} = 7'h00;
		{dc_measure_done, temp_prewarn, temp_max} = 3'h0;
		{current_upper, load_open, load_line, current_mismatch, short_fault, offset_high, clip_detect} = 14'h0000;
		errors = 0;
		n_compared = 0;
		void'($urandom(32'hc41c));
		repeat (4) @(negedge clock);
		reset = 1'b0;
		settle();
		rd(24'hffffff, {CH_RESET, CH_RESET, SHARED_RESET});
		i2c_mode = 1'b1;
		host_model_inst.write_ctrl(24'h018010);
		settle();
		check("level select", {clip_level_high, prewarn_level_low}, 2'b11);
		host_model_inst.write_ctrl(24'h010000);
		rd(24'hffffff, 24'h000080);
		rd(24'hffffff, 24'h000000);
		check("fault pin", fault_oe, 1'b0);
		offset_high = 2'b01;
		settle();
		check("fault pin", fault_oe, 1'b1);
		rd(24'h040400, 24'h000000);
		rd(24'h040400, 24'h040000);
		offset_high = 2'b00;
		short_fault = 2'b01;
		settle();
		check("fault pin", fault_oe, 1'b1);
		short_fault = 2'b00;
		settle();
		check("fault pin", fault_oe, 1'b0);
		rd(24'h010000, 24'h010000);
		rd(24'h010000, 24'h000000);
		clip_detect = 2'b01;
		settle();
		check("pins", {od_oe, fault_oe}, 2'b10);
		host_model_inst.write_ctrl(24'h411200);
		settle();
		check("pins", {od_oe, fault_oe}, 2'b11);
		{clip_detect, offset_high} = 4'b0001;
		settle();
		check("pins", {od_oe, fault_oe}, 2'b00);
		host_model_inst.write_ctrl(24'h010000);
		offset_high = 2'b00;
		temp_max = 1'b1;
		temp_prewarn = 1'b1;
		settle();
		check("channels off", {channel_off, gain_reduce, od_oe}, 4'hf);
		rd(24'h000060, 24'h000060);
		{temp_max, temp_prewarn} = 2'b00;
		current_mismatch = 2'($urandom_range(2, 3));
		settle();
		check("channels off", channel_off, current_mismatch);
		rd(24'h404000, {1'b0, current_mismatch[0], 7'h00, current_mismatch[1], 14'h0000});
		current_mismatch = 2'b00;
		startup_complete = 1'b1;
		host_model_inst.write_ctrl(24'h050000);
		crossings($urandom_range(1, 2));
		settle();
		rd(24'h808000, 24'h000000);
		crossings(3);
		settle();
		rd(24'h808000, 24'h808000);
		rd(24'h808000, 24'h808000);
		check("fault pin", fault_oe, 1'b0);
		host_model_inst.write_ctrl(24'h010000);
		settle();
		rd(24'h808000, 24'h000000);
		startup_complete = 1'b0;
		startup_active = 1'b1;
		settle();
		check("offset ramp", dc_offset_ramp, 1'b0);
		startup_active = 1'b0;
		host_model_inst.write_ctrl(24'h030000);
		startup_active = 1'b1;
		settle();
		check("offset ramp", dc_offset_ramp, 1'b1);
		{load_open, load_line, dc_measure_done} = 5'b01101;
		settle();
		{startup_active, dc_measure_done} = 2'b00;
		settle();
		rd(24'h303008, 24'h102008);
		{svr_above_low, startup_active} = 2'b11;
		settle();
		{svr_above_low, dc_measure_done} = 2'b01;
		settle();
		{startup_active, dc_measure_done} = 2'b00;
		settle();
		rd(24'h000008, 24'h000000);
		{startup_active, supply_low} = 2'b11;
		settle();
		dc_measure_done = 1'b1;
		settle();
		{startup_active, supply_low, dc_measure_done} = 3'b000;
		settle();
		rd(24'h000008, 24'h000000);
		{svr_above_half, dc_settling_near} = 2'b11;
		settle();
		rd(24'h000010, 24'h000010);
		i2c_mode = 1'b0;
		settle();
		check("level select", {clip_level_high, prewarn_level_low}, 2'b00);
		complete_run();
	end
endmodule

// ### src/amp_fault_indicator_pin_pkg.sv
// Bit positions, reset values and counts for the amplifier diagnostic block.
// Assumes control bytes arrive from a serial-bus front end on the same clock.
// Operation
// - DC load detect off unless enabled
// - Store load class in open/line bits
// - Load bits valid only with valid flag
// - Clear valid on charged node or dip
// - AC detect starts on enable rising edge
// - Upper current threshold qualifies AC flag
// - AC flag after three upper crossings
// - Counter reset only by enable clear
// - AC result in status bit seven
// - AC detect only after start-up completes
// - Indicator pins open-drain, active low
// - Indicators OR fixed and enabled conditions
// - Status latches, clears on read
// - Load results never drive indicators
// - Overdrive level select, default 3 percent
// - Pre-warning level select, default 145 C
// - Pre-warning reduces gain, max temp off
// - Current mismatch switches channel off
// - Read sets offset bits, window clears
// - Offset drives fault pin when selected
// - Settling bit when node reaches half
// - Reset clears all control bits
// - AC flags survive read, cleared by enable
package amp_fault_indicator_pin_pkg;
	localparam int unsigned CH_CNT = 2;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// control_byte_one
	localparam int unsigned C1_STANDBY_N = 0;
	localparam int unsigned C1_DC_EN = 1;
	localparam int unsigned C1_AC_EN = 2;
	localparam int unsigned C1_PREWARN_ON_PIN = 4;
	localparam int unsigned C1_CLIP2_ON_PIN = 5;
	localparam int unsigned C1_CLIP1_ON_PIN = 6;
	// control_byte_two (pin bits set mean "not on pin"; C2_CLIP_LEVEL set selects the high clip level)
	localparam int unsigned C2_NO_OFFSET_ON_PIN = 1;
	localparam int unsigned C2_NO_SPK_ON_PIN = 4;
	localparam int unsigned C2_CLIP_LEVEL = 7;
	// control_byte_three
	localparam int unsigned C3_PREWARN_LEVEL = 4;
	// channel status bytes
	localparam int unsigned S_SHORT = 0;
	localparam int unsigned S_OFFSET = 2;
	localparam int unsigned S_OPEN = 4;
	localparam int unsigned S_LINE = 5;
	localparam int unsigned S_SPK = 6;
	localparam int unsigned S_AC = 7;
	// shared_status_byte
	localparam int unsigned SH_DC_VALID = 3;
	localparam int unsigned SH_SETTLED = 4;
	localparam int unsigned SH_PREWARN = 5;
	localparam int unsigned SH_MAXTEMP = 6;
	localparam int unsigned SH_POR = 7;
	localparam logic [7:0] SHARED_RESET = 8'h80;
	localparam logic [7:0] CH_RESET = 8'h00;
	// Bits kept across a read
	localparam logic [7:0] CH_KEEP_MASK = 8'hb0;
	localparam logic [1:0] AC_CROSSINGS = 2'h3;
	// Analog comparator inputs, index into synchronised vector
	localparam int unsigned A_W = 16;
	localparam int unsigned A_I2C = 0;
	localparam int unsigned A_STARTUP = 1;
	localparam int unsigned A_STARTED = 2;
	localparam int unsigned A_SVR_HI = 3;
	localparam int unsigned A_SVR_HALF = 4;
	localparam int unsigned A_VP_LOW = 5;
	localparam int unsigned A_DC_DONE = 6;
	localparam int unsigned A_PREWARN = 7;
	localparam int unsigned A_MAXTEMP = 8;
	localparam int unsigned A_UPPER = 9;
	localparam int unsigned A_OPEN = 11;
	localparam int unsigned A_LINE = 13;
	localparam int unsigned A_SETTLING = 15;
	typedef enum logic [1:0] {
		DC_IDLE = 2'b00,
		DC_RAMP = 2'b01,
		DC_DONE = 2'b10
	} dc_state_t;
endpackage

// ### src/amp_load_fault_indicator_pin_reporting.sv
// Load identification and diagnostic reporting for a two-channel amplifier.
// Assumes analog comparators and mode straps are asynchronous to clock;
// control bytes and the read strobe come from logic on clock.
`timescale 1ns/100ps
module amp_load_fault_indicator_pin_reporting
	import amp_fault_indicator_pin_pkg::*;
(
	// System
	input wire logic clock,
	input wire logic reset,
	// Control bytes from the serial-bus front end
	input wire logic control_write,
	input wire logic [7:0] control_byte_one,
	input wire logic [7:0] control_byte_two,
	input wire logic [7:0] control_byte_three,
	input wire logic status_read,
	// Asynchronous mode and start-up levels
	input wire logic i2c_mode,
	input wire logic startup_active,
	input wire logic startup_complete,
	input wire logic svr_above_low,
	input wire logic svr_above_half,
	input wire logic dc_settling_near,
	input wire logic supply_low,
	input wire logic dc_measure_done,
	// Asynchronous analog comparators
	input wire logic temp_prewarn,
	input wire logic temp_max,
	input wire logic [1:0] current_upper,
	input wire logic [1:0] load_open,
	input wire logic [1:0] load_line,
	input wire logic [1:0] current_mismatch,
	input wire logic [1:0] short_fault,
	input wire logic [1:0] offset_high,
	input wire logic [1:0] clip_detect,
	// Status bytes
	output logic [7:0] channel_one_status_byte,
	output logic [7:0] channel_two_status_byte,
	output logic [7:0] shared_status_byte,
	// Analog controls
	output logic dc_offset_ramp,
	output logic clip_level_high,
	output logic prewarn_level_low,
	output logic gain_reduce,
	output logic [1:0] channel_off,
	// Open-drain indicator pins
	input wire logic fault_indicator_pin_in,
	output logic fault_indicator_pin_out,
	output logic fault_indicator_pin_oe,
	input wire logic overdrive_pin_in,
	output logic overdrive_pin_out,
	output logic overdrive_pin_oe
);
	logic [A_W-1:0] async_in;
	logic [A_W-1:0] meta_r;
	logic [A_W-1:0] sync_r;
	logic [A_W-1:0] sync_d_r;
	logic [7:0] ctrl1_r, ctrl1_nxt;
	logic [7:0] ctrl2_r, ctrl2_nxt;
	logic [7:0] ctrl3_r, ctrl3_nxt;
	logic [7:0] ch_r [CH_CNT], ch_nxt [CH_CNT];
	logic [7:0] sh_r, sh_nxt;
	logic [1:0] cross_r [CH_CNT], cross_nxt [CH_CNT];
	logic ac_armed_r, ac_armed_nxt;
	logic ac_en_d_r;
	dc_state_t dc_r, dc_nxt;
	logic fault_oe_r, fault_oe_nxt;
	logic over_oe_r, over_oe_nxt;
	logic clip_hi_r, clip_hi_nxt;
	logic pw_low_r, pw_low_nxt;
	logic gain_red_r, gain_red_nxt;
	logic [1:0] ch_off_r, ch_off_nxt;
	logic por_live_r, por_live_nxt;
	// Ripple node state at the start of detection
	logic svr_charged_r, svr_charged_nxt;
	logic ramp_r, ramp_nxt;

	// Pins stay high-impedance except when pulling low
	logic zero_r;

	assign async_in = {dc_settling_near, load_line, load_open, current_upper, temp_max, temp_prewarn,
		dc_measure_done, supply_low, svr_above_half, svr_above_low, startup_complete, startup_active,
		i2c_mode};

	// Edge of a synchronised level against its one-cycle-old copy
	function automatic logic rise(input logic now, input logic was);
		return now & ~was;
	endfunction

	// Uncommon comparators that are only levels go through the same synchroniser
	logic [1:0] mism_meta_r, mism_r, short_meta_r, short_r, off_meta_r, off_r, clip_meta_r, clip_r;

	logic i2c, started, vp_low, prewarn, maxtemp, ac_en;
	always_comb begin
		i2c = sync_r[A_I2C];
		started = sync_r[A_STARTED];
		vp_low = sync_r[A_VP_LOW];
		prewarn = sync_r[A_PREWARN];
		maxtemp = sync_r[A_MAXTEMP];
		ac_en = ctrl1_r[C1_AC_EN];
	end

	always_comb begin
		ctrl1_nxt = ctrl1_r;
		ctrl2_nxt = ctrl2_r;
		ctrl3_nxt = ctrl3_r;
		if (control_write) begin
			ctrl1_nxt = control_byte_one;
			ctrl2_nxt = control_byte_two;
			ctrl3_nxt = control_byte_three;
		end
		dc_nxt = dc_r;
		sh_nxt = sh_r;
		por_live_nxt = por_live_r;
		ac_armed_nxt = ac_armed_r;
		svr_charged_nxt = svr_charged_r;
		for (int c = 0; c < CH_CNT; c++) begin
			ch_nxt[c] = ch_r[c];
			cross_nxt[c] = cross_r[c];
		end
		// Read clears history; sets below take priority over it
		if (status_read) begin
			sh_nxt = 8'h00;
			por_live_nxt = 1'b0;
			for (int c = 0; c < CH_CNT; c++) begin
				ch_nxt[c] = ch_r[c] & CH_KEEP_MASK;
			end
		end
		sh_nxt[SH_DC_VALID] = sh_r[SH_DC_VALID];
		// DC load measurement during start-up
		case (dc_r)
			DC_IDLE: begin
				if (ctrl1_r[C1_DC_EN] && i2c && rise(sync_r[A_STARTUP], sync_d_r[A_STARTUP])) begin
					dc_nxt = DC_RAMP;
					// Node level matters only at the start edge
					svr_charged_nxt = sync_r[A_SVR_HI];
					sh_nxt[SH_DC_VALID] = 1'b0;
				end
			end
			DC_RAMP: begin
				if (vp_low) begin
					dc_nxt = DC_DONE;
					sh_nxt[SH_DC_VALID] = 1'b0;
				end else if (rise(sync_r[A_DC_DONE], sync_d_r[A_DC_DONE])) begin
					dc_nxt = DC_DONE;
					// Charged ripple node at start spoils the result
					sh_nxt[SH_DC_VALID] = ~svr_charged_r & ~sync_d_r[A_SETTLING] & ~sh_r[SH_SETTLED];
					for (int c = 0; c < CH_CNT; c++) begin
						ch_nxt[c][S_OPEN] = sync_r[A_OPEN + c];
						ch_nxt[c][S_LINE] = sync_r[A_LINE + c] & ~sync_r[A_OPEN + c];
					end
				end
			end
			DC_DONE: begin
				if (!sync_r[A_STARTUP]) begin
					dc_nxt = DC_IDLE;
				end
			end
			default: dc_nxt = DC_IDLE;
		endcase
		// AC detection armed by enable edge, only after start-up
		if (!ac_en) begin
			ac_armed_nxt = 1'b0;
			for (int c = 0; c < CH_CNT; c++) begin
				cross_nxt[c] = 2'h0;
				ch_nxt[c][S_AC] = 1'b0;
			end
		end else begin
			if (rise(ac_en, ac_en_d_r)) begin
				ac_armed_nxt = 1'b1;
			end
			if (ac_armed_r && started && dc_r != DC_RAMP) begin
				for (int c = 0; c < CH_CNT; c++) begin
					// Saturating count; only the enable clear brings it back
					if (rise(sync_r[A_UPPER + c], sync_d_r[A_UPPER + c]) && cross_r[c] != AC_CROSSINGS) begin
						cross_nxt[c] = cross_r[c] + 2'h1;
					end
					if (cross_r[c] == AC_CROSSINGS) begin
						ch_nxt[c][S_AC] = 1'b1;
					end
				end
			end
		end
		// Latched faults: set wins over a same-cycle read
		for (int c = 0; c < CH_CNT; c++) begin
			if (mism_r[c]) ch_nxt[c][S_SPK] = 1'b1;
			if (short_r[c]) ch_nxt[c][S_SHORT] = 1'b1;
			// A read arms the offset check; the window then clears it
			if (i2c && status_read) begin
				ch_nxt[c][S_OFFSET] = 1'b1;
			end else if (!off_r[c]) begin
				ch_nxt[c][S_OFFSET] = 1'b0;
			end
		end
		if (maxtemp) sh_nxt[SH_MAXTEMP] = 1'b1;
		if (prewarn) sh_nxt[SH_PREWARN] = 1'b1;
		// Standby holds the power-on bit set
		if (!ctrl1_r[C1_STANDBY_N]) sh_nxt[SH_POR] = 1'b1;
		if (sync_r[A_SETTLING] && sync_r[A_SVR_HALF]) sh_nxt[SH_SETTLED] = 1'b1;
		// Registered copy keeps the ramp output glitch-free
		ramp_nxt = (dc_nxt == DC_RAMP);
	end

	// Analog steering and indicator pins from live conditions
	logic fault_any, clip_any;
	always_comb begin
		clip_hi_nxt = i2c & ctrl2_r[C2_CLIP_LEVEL];
		pw_low_nxt = i2c & ctrl3_r[C3_PREWARN_LEVEL];
		gain_red_nxt = prewarn;
		// Shutdown is live, not latched, so channels recover when cool
		ch_off_nxt = mism_r | {CH_CNT{maxtemp}};
		clip_any = |clip_r;
		// Load results deliberately absent from both pins
		if (i2c) begin
			fault_any = por_live_r | vp_low | maxtemp
				| (ctrl1_r[C1_CLIP1_ON_PIN] & clip_r[0])
				| (ctrl1_r[C1_CLIP2_ON_PIN] & clip_r[1])
				| (ctrl1_r[C1_PREWARN_ON_PIN] & prewarn)
				| (~ctrl2_r[C2_NO_SPK_ON_PIN] & (|mism_r | |short_r))
				| (~ctrl2_r[C2_NO_OFFSET_ON_PIN] & |off_r);
		end else begin
			fault_any = vp_low | maxtemp | |mism_r | |short_r | |off_r;
		end
		fault_oe_nxt = fault_any;
		over_oe_nxt = clip_any | prewarn;
	end

	// Synchronisers and edge history carry no reset, so no false edge on release
	always_ff @(posedge clock) begin
		meta_r <= async_in;
		sync_r <= meta_r;
		mism_meta_r <= current_mismatch;
		mism_r <= mism_meta_r;
		short_meta_r <= short_fault;
		short_r <= short_meta_r;
		off_meta_r <= offset_high;
		off_r <= off_meta_r;
		clip_meta_r <= clip_detect;
		clip_r <= clip_meta_r;
		sync_d_r <= sync_r;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl1_r <= CTRL_RESET;
			ctrl2_r <= CTRL_RESET;
			ctrl3_r <= CTRL_RESET;
			for (int c = 0; c < CH_CNT; c++) begin
				ch_r[c] <= CH_RESET;
				cross_r[c] <= 2'h0;
			end
			sh_r <= SHARED_RESET;
			ac_armed_r <= 1'b0;
			ac_en_d_r <= 1'b0;
			dc_r <= DC_IDLE;
			fault_oe_r <= 1'b0;
			over_oe_r <= 1'b0;
			clip_hi_r <= 1'b0;
			pw_low_r <= 1'b0;
			gain_red_r <= 1'b0;
			ch_off_r <= 2'h0;
			por_live_r <= 1'b1;
			zero_r <= 1'b0;
			svr_charged_r <= 1'b0;
			ramp_r <= 1'b0;
		end else begin
			ctrl1_r <= ctrl1_nxt;
			ctrl2_r <= ctrl2_nxt;
			ctrl3_r <= ctrl3_nxt;
			for (int c = 0; c < CH_CNT; c++) begin
				ch_r[c] <= ch_nxt[c];
				cross_r[c] <= cross_nxt[c];
			end
			sh_r <= sh_nxt;
			ac_armed_r <= ac_armed_nxt;
			ac_en_d_r <= ac_en;
			dc_r <= dc_nxt;
			fault_oe_r <= fault_oe_nxt;
			over_oe_r <= over_oe_nxt;
			clip_hi_r <= clip_hi_nxt;
			pw_low_r <= pw_low_nxt;
			gain_red_r <= gain_red_nxt;
			ch_off_r <= ch_off_nxt;
			por_live_r <= por_live_nxt;
			zero_r <= 1'b0;
			svr_charged_r <= svr_charged_nxt;
			ramp_r <= ramp_nxt;
		end
	end

	assign channel_one_status_byte = ch_r[0];
	assign channel_two_status_byte = ch_r[1];
	assign shared_status_byte = sh_r;
	assign dc_offset_ramp = ramp_r;
	assign clip_level_high = clip_hi_r;
	assign prewarn_level_low = pw_low_r;
	assign gain_reduce = gain_red_r;
	assign channel_off = ch_off_r;
	assign fault_indicator_pin_out = zero_r;
	assign fault_indicator_pin_oe = fault_oe_r;
	assign overdrive_pin_out = zero_r;
	assign overdrive_pin_oe = over_oe_r;
endmodule
